// ===== logic/sdc_slave.sv
// two-wire slave port, code register and standby control of the converter
// assumes open-drain bus lines pulled up outside; the bus clock is far slower than clock
`timescale 1ns/1ps
module sdc_slave #(
  parameter int POR_CYCLES = sdc_pkg::POR_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // converter side
  output logic [9:0] dac_code,
  output logic dac_run,
  output logic standby,
  output logic por_done
);
  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;
  sdc_sync u_scl (.clock(clock), .rst(rst), .pin_in(scl_in), .level(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  sdc_sync u_sda (.clock(clock), .rst(rst), .pin_in(sda_in), .level(sda_lvl), .rise(sda_rise), .fall(sda_fall));

  sdc_pkg::sdc_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic [7:0] cmd_reg;
  logic [1:0] byte_reg;
  logic rw_reg;
  logic [7:0] first_reg;
  logic [9:0] code_reg;
  logic stby_reg;
  logic drive_low_reg;
  logic [31:0] por_cnt_reg;
  logic por_reg;
  logic run_reg;

  wire start_c = sda_fall & scl_lvl;
  wire stop_c = sda_rise & scl_lvl;

  // byte the slave would send for a command; second code byte carries the two low bits on top
  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic second, input logic [9:0] code,
                                           input logic sb);
    logic [7:0] r;
    r = 8'h00;
    if (cmd == sdc_pkg::CMD_CODE) begin // R13
      r = second ? {code[1:0], 6'h00} : code[9:2]; // R15
    end else if (cmd == sdc_pkg::CMD_SETUP) begin
      r = {7'h00, sb}; // R14
    end
    return r;
  endfunction

  // first byte of a read; a function result cannot be bit-selected directly
  logic [7:0] first_tx;
  assign first_tx = read_byte(cmd_reg, 1'b0, code_reg, stby_reg);

  // power-on delay: registers hold reset values until it runs out
  always_ff @(posedge clock) begin
    if (rst) begin
      por_cnt_reg <= 32'h0;
      por_reg <= 1'b0;
    end else if (!por_reg) begin
      if (por_cnt_reg == 32'(POR_CYCLES - 1)) por_reg <= 1'b1; // R10
      por_cnt_reg <= por_cnt_reg + 32'h1;
    end
  end

  // protocol engine; all bit timing comes from the master's clock edges
  always_ff @(posedge clock) begin
    if (rst || !por_reg) begin
      state_reg <= sdc_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      cmd_reg <= sdc_pkg::CMD_RST;
      byte_reg <= 2'h0;
      rw_reg <= 1'b0;
      first_reg <= 8'h00;
      code_reg <= sdc_pkg::CODE_RST; // R10
      stby_reg <= sdc_pkg::STBY_RST;
      drive_low_reg <= 1'b0;
    end else if (start_c) begin
      state_reg <= sdc_pkg::ST_ADDR;
      bit_reg <= 4'h0;
      drive_low_reg <= 1'b0;
    end else if (stop_c) begin
      state_reg <= sdc_pkg::ST_IDLE;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        sdc_pkg::ST_ADDR, sdc_pkg::ST_RX: begin
          if (scl_rise) begin // R02
            shift_reg <= {shift_reg[6:0], sda_lvl};
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            if (state_reg == sdc_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == sdc_pkg::DEV_ADDR) begin // R03 R16
                rw_reg <= shift_reg[0];
                byte_reg <= 2'h0;
                drive_low_reg <= 1'b1;
                state_reg <= sdc_pkg::ST_AACK;
              end else begin
                state_reg <= sdc_pkg::ST_IDLE;
              end
            end else begin
              drive_low_reg <= 1'b1; // R04
              state_reg <= sdc_pkg::ST_RACK;
              if (byte_reg == 2'h0) begin
                cmd_reg <= shift_reg;
              end else if (cmd_reg == sdc_pkg::CMD_SETUP) begin // R05 R13
                stby_reg <= shift_reg[sdc_pkg::STBY_BIT]; // R07 R09
              end else if (cmd_reg == sdc_pkg::CMD_CODE) begin
                if (byte_reg == 2'h1) first_reg <= shift_reg;
                else code_reg <= {first_reg, shift_reg[7:6]}; // R15 R06
              end // R12
              if (byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
            end
          end
        end
        sdc_pkg::ST_AACK, sdc_pkg::ST_RACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            if (state_reg == sdc_pkg::ST_AACK && rw_reg) begin
              shift_reg <= first_tx;
              drive_low_reg <= ~first_tx[7]; // R01
              byte_reg <= 2'h1;
              state_reg <= sdc_pkg::ST_TX;
            end else begin
              drive_low_reg <= 1'b0;
              state_reg <= sdc_pkg::ST_RX;
            end
          end
        end
        sdc_pkg::ST_TX: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              drive_low_reg <= 1'b0;
              state_reg <= sdc_pkg::ST_TACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              drive_low_reg <= ~shift_reg[6];
            end
          end
        end
        sdc_pkg::ST_TACK: begin
          if (scl_rise) begin
            if (sda_lvl) begin
              state_reg <= sdc_pkg::ST_IDLE; // master nack ends the read
            end else begin
              shift_reg <= read_byte(cmd_reg, byte_reg[0], code_reg, stby_reg);
              byte_reg <= 2'h2;
            end
          end else if (scl_fall) begin
            bit_reg <= 4'h0;
            drive_low_reg <= ~shift_reg[7];
            state_reg <= sdc_pkg::ST_TX;
          end
        end
        default: state_reg <= sdc_pkg::ST_IDLE;
      endcase
    end
  end

  // standby only gates the converter; the code register is untouched
  always_ff @(posedge clock) begin
    if (rst) run_reg <= 1'b0;
    else run_reg <= por_reg & ~stby_reg; // R08 R11
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      dac_code <= sdc_pkg::CODE_RST;
      standby <= 1'b0;
      por_done <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_low_reg; // R01
      dac_code <= code_reg; // R06
      standby <= stby_reg;
      por_done <= por_reg;
    end
  end
  assign dac_run = run_reg;

  chk_standby_halts: assert property (@(posedge clock) disable iff (rst)
    stby_reg |-> ##1 !dac_run) else $error("converter runs in standby"); // R08
  chk_code_kept: assert property (@(posedge clock) disable iff (rst)
    $rose(stby_reg) |-> ##[1:2] $stable(dac_code)) else $error("code changed at standby"); // R11
  chk_never_high: assert property (@(posedge clock) disable iff (rst)
    !sda_oe_n |-> sda_out == 1'b0) else $error("data driven high"); // R01
  chk_addr_ack: assert property (@(posedge clock) disable iff (rst)
    state_reg == sdc_pkg::ST_AACK |-> shift_reg[7:1] == sdc_pkg::DEV_ADDR) else $error("ack on wrong address"); // R16
  chk_por_hold: assert property (@(posedge clock) disable iff (rst)
    !por_reg |-> code_reg == sdc_pkg::CODE_RST && !stby_reg) else $error("registers not reset"); // R10
  chk_idle_release: assert property (@(posedge clock) disable iff (rst)
    state_reg == sdc_pkg::ST_IDLE |-> ##1 sda_oe_n) else $error("drive in idle"); // R01
  chk_setup_load: assert property (@(posedge clock) disable iff (rst)
    $changed(stby_reg) && por_reg |-> $past(cmd_reg) == sdc_pkg::CMD_SETUP) else $error("bad setup load"); // R05
  chk_code_load: assert property (@(posedge clock) disable iff (rst)
    $changed(code_reg) && por_reg |-> $past(cmd_reg) == sdc_pkg::CMD_CODE) else $error("bad code load"); // R12
  chk_run_follows: assert property (@(posedge clock) disable iff (rst) // R07
    por_reg && !stby_reg |=> dac_run) else $error("converter idle in normal mode");
  chk_code_out: assert property (@(posedge clock) disable iff (rst) // R06
    $changed(code_reg) |=> dac_code == $past(code_reg)) else $error("code not presented");
  chk_standby_out: assert property (@(posedge clock) disable iff (rst) // R07
    $changed(stby_reg) |=> standby == $past(stby_reg)) else $error("standby not presented");
  chk_mismatch_noack: assert property (@(posedge clock) disable iff (rst) // R16
    state_reg == sdc_pkg::ST_ADDR && scl_fall && bit_reg == 4'h8 && shift_reg[7:1] != sdc_pkg::DEV_ADDR
    |=> !drive_low_reg) else $error("ack on foreign address");
  chk_rx_ack: assert property (@(posedge clock) disable iff (rst) // R02
    state_reg == sdc_pkg::ST_RACK |-> drive_low_reg) else $error("received byte not acked");
  chk_tx_release: assert property (@(posedge clock) disable iff (rst) // R01
    state_reg == sdc_pkg::ST_TACK |-> !drive_low_reg) else $error("data held during master ack");
  chk_port_standby: assert property (@(posedge clock) disable iff (rst) // R09
    stby_reg && state_reg == sdc_pkg::ST_IDLE && start_c |=> state_reg == sdc_pkg::ST_ADDR)
    else $error("port deaf in standby");
  chk_setup_zero: assert property (@(posedge clock) disable iff (rst) // R14
    state_reg == sdc_pkg::ST_AACK && rw_reg && scl_fall && cmd_reg == sdc_pkg::CMD_SETUP
    |=> shift_reg[7:1] == 7'h00) else $error("reserved setup bits not zero");
  chk_code_first: assert property (@(posedge clock) disable iff (rst) // R15
    state_reg == sdc_pkg::ST_AACK && rw_reg && scl_fall && cmd_reg == sdc_pkg::CMD_CODE
    |=> shift_reg == code_reg[9:2]) else $error("code read starts wrong");
  chk_por_count: assert property (@(posedge clock) disable iff (rst) // R10
    $rose(por_reg) |-> por_cnt_reg == 32'(POR_CYCLES)) else $error("power-on delay wrong");
endmodule

// ===== inc/sdc_pkg.sv
// constants and types for the serial converter control slave
// assumes a 50 MHz system clock and a slow two-wire bus sampled by it
// How it works
// [R01] The block is only a bus slave: it never drives the clock and drives data only to acknowledge or transmit.
// [R02] The bus clock shifts bits both in and out, and the one data line carries traffic both ways.
// [R03] The block answers to the seven-bit address 1001000b, held as a build-time constant.
// [R04] A host writes one byte as start, address with write bit, command byte, data byte, stop, each byte acknowledged.
// [R05] A received data byte goes into the register chosen by the command byte earlier in the same write.
// [R06] A 10-bit output code is held and presented to the converter, full scale being code over 1024 of reference.
// [R07] Setting the standby request bit enters standby and clearing it returns to normal operation.
// [R08] Conversion is halted while in standby.
// [R09] The serial port keeps working fully during standby.
// [R10] A power-on reset puts every register into a known state, typically 500 us after supply rise.
// [R11] The stored output code is kept unchanged across standby entry and exit.
// [R12] Data bytes with an unknown command code are ignored while the transaction completes normally.
// [R13] Command 00h selects the code register and command 01h selects the setup register, for reads and writes.
// [R14] Setup bit 0 is the standby request, reset to 0, and bits 7 to 1 read as zero.
// [R15] The code travels as two bytes: bits 9..2 first, then bits 1..0 in the top two positions of the second.
// [R16] The address byte is acknowledged only on a match of its seven bits; the eighth bit is 1 for read.
package sdc_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h48;
  localparam logic [7:0] CMD_CODE = 8'h00;
  localparam logic [7:0] CMD_SETUP = 8'h01;
  localparam logic [7:0] CMD_RST = 8'hFF;
  localparam int STBY_BIT = 0;
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic STBY_RST = 1'b0;
  localparam int CLK_MHZ = 50;
  localparam int POR_US = 500;
  localparam int POR_CYC = POR_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RX = 3'b010,
    ST_RACK = 3'b110,
    ST_TX = 3'b111,
    ST_TACK = 3'b101
  } sdc_state_t;
endpackage

// ===== logic/sdc_sync.sv
// two-flop synchroniser with edge outputs taken from the second stage onward
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module sdc_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // line in
  input wire logic pin_in,
  // conditioned outputs
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

// ===== sim/sdc_host_model.sv
// two-wire bus master model that drives the slave's clock and data pins
// assumes an open-drain data line resolved by the bench, pulled up when released
`timescale 1ns/1ps
module sdc_host_model (
  // clock
  input wire logic clock,
  // resolved data line
  input wire logic sda_line,
  // master drives
  output logic scl,
  output logic sda
);
  // the bus clock idles high between frames, like a real pulled-up line
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // also serves as repeated start, since it raises data first
  task automatic start();
    sda <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b1;
    tick(4);
  endtask
  // data moves only while the clock is low; sampled mid-high, off the edge
  // low phase of five clocks outlasts the slave's four-clock answer, so its data never moves with the rise
  task automatic bit_io(input logic b, output logic r);
    sda <= b;
    tick(4);
    scl <= 1'b1;
    tick(1);
    @(negedge clock) r = sda_line;
    tick(2);
    scl <= 1'b0;
    tick(1);
  endtask
  // eight bits msb first, then the ninth clock for the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the converter control slave
// assumes the package is compiled first and the host model is on the bus
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  wire logic scl;
  wire logic host_sda;
  wire logic sda_line;
  logic sda_out, sda_oe_n, dac_run, standby, por_done, addr_ack, data_nak;
  logic [9:0] dac_code, code, exp_code;
  logic [7:0] rd0, rd1, b2, sb;
  int mismatches = 0;
  int cmp_count = 0;
  always #10 clock = ~clock;
  assign sda_line = host_sda & (sda_oe_n | sda_out);
  sdc_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(host_sda));
  sdc_slave #(.POR_CYCLES(20)) i_sdc_slave (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dac_code(dac_code), .dac_run(dac_run), .standby(standby),
    .por_done(por_done));
  function automatic logic [9:0] join_code(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo[7:6]};
  endfunction
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // write nd data bytes, then optionally read nrd bytes after a repeated start
  task automatic frame(input logic [6:0] a, input logic [7:0] c, b1, bb, input int nd, nrd);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k);
    addr_ack = ~k;
    data_nak = 1'b0;
    if (addr_ack) begin
      host.xfer(c, 1'b1, q, k);
      data_nak |= k;
      if (nd > 0) host.xfer(b1, 1'b1, q, k);
      if (nd > 0) data_nak |= k;
      if (nd > 1) host.xfer(bb, 1'b1, q, k);
      if (nd > 1) data_nak |= k;
      if (nrd > 0) begin
        host.start();
        host.xfer({a, 1'b1}, 1'b1, q, k);
        data_nak |= k;
        host.xfer(8'hFF, nrd == 1, rd0, k);
        if (nrd > 1) host.xfer(8'hFF, 1'b1, rd1, k);
      end
    end
    host.stop();
  endtask
  initial begin
    repeat (50000) @(posedge clock);
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(32'hC0947007));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("dac_code", 10'h000, dac_code);
    chk("standby", 1'b0, standby);
    repeat (8) @(negedge clock);
    chk("por_done", 1'b0, por_done);
    repeat (20) @(negedge clock);
    chk("por_done", 1'b1, por_done);
    chk("dac_run", 1'b1, dac_run);
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 10'h3FF : 10'($urandom);
      b2 = {code[1:0], 6'($urandom)};
      exp_code = join_code(code[9:2], b2);
      frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_CODE, code[9:2], b2, 2, 0);
      chk("addr_ack", 1'b1, addr_ack);
      chk("data_ack", 1'b0, data_nak);
      chk("dac_code", exp_code, dac_code);
    end
    frame(sdc_pkg::DEV_ADDR ^ 7'(1 << ($urandom % 7)), sdc_pkg::CMD_CODE, 8'h00, 8'h00, 2, 0);
    chk("addr_ack", 1'b0, addr_ack);
    chk("dac_code", exp_code, dac_code);
    sb = 8'($urandom) | 8'h01;
    frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_SETUP, sb, 8'h00, 1, 0);
    chk("standby", 1'b1, standby);
    chk("dac_run", 1'b0, dac_run);
    chk("dac_code", exp_code, dac_code);
    frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_SETUP, 8'h00, 8'h00, 0, 1);
    chk("setup_read", 8'h01, rd0);
    frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_CODE, 8'h00, 8'h00, 0, 2);
    chk("code_hi", exp_code[9:2], rd0);
    chk("code_lo", exp_code[1:0], rd1[7:6]);
    code = 10'($urandom);
    exp_code = join_code(code[9:2], {code[1:0], 6'h3F});
    frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_CODE, code[9:2], {code[1:0], 6'h3F}, 2, 0);
    chk("dac_code", exp_code, dac_code);
    frame(sdc_pkg::DEV_ADDR, 8'(2 + $urandom % 250), 8'hFF, 8'hFE, 2, 0);
    chk("data_ack", 1'b0, data_nak);
    chk("dac_code", exp_code, dac_code);
    chk("standby", 1'b1, standby);
    frame(sdc_pkg::DEV_ADDR, sdc_pkg::CMD_SETUP, 8'hFE, 8'h00, 1, 0);
    chk("standby", 1'b0, standby);
    chk("dac_run", 1'b1, dac_run);
    chk("dac_code", exp_code, dac_code);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("dac_code", sdc_pkg::CODE_RST, dac_code);
    chk("por_done", 1'b0, por_done);
    summarize();
  end
endmodule
